//--- xtc_trim_calib.v
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - Trim code 0x00 is least capacitance, 0xff most, in 256 steps.
// - Bits 4:0 drive binary caps; bits 7:5 become a seven-line thermometer.
// - Ready interrupt rises when ready counter reaches the programmed limit.
// - Ready counter runs on fast RC at power-up, low-power clock at wake.
// - Hardware alone enables the fast crystal at power-up or wake-up.
// - Start-up phase ends applying stored trim; settling follows before interrupt.
// - Counter mode applies trim at count minus one; current mode on current drop.
// - Current mode copies ready counter into shadow when trim applies.
// - Settle flag sets when crystal cycle counter reaches the settle threshold.
// - Core runs from fast RC until the ready interrupt rises.
// - Start-up sequencer slow RC switches from 32 kHz to 512 kHz.
// - Slow crystal has no trim and clocks deep sleep modes.
// - Software loads reference count; larger gives longer, finer measurement.
// - Measures selected oscillator against 16 MHz crystal clock; select 0 to 3.
// - Start bit clears at completion; 32-bit result split high and low.
`include "xtc_map.vh"
module xtc_trim_calib #(
  parameter RDY_W = 16,
  parameter REF_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire power_up_start,
  input wire wake_start,
  input wire lp_clk_tick,
  input wire xtal_current_drop,
  input wire fast_crystal_tick,
  input wire ref_tick_16m,
  input wire [3:0] osc_ticks,
  output reg fast_crystal_en_ff,
  output reg [4:0] trim_binary_caps_ff,
  output reg [6:0] trim_thermo_caps_ff,
  output reg crystal_ready_irq_ff,
  output reg core_on_fast_rc_ff,
  output reg slow_rc_fast_sel_ff,
  output reg slow_crystal_sleep_clk_ff
);
////////////////////////////////////////////////////////////////////////////////
reg [7:0] crystal_trim_code_ff;
reg [7:0] stored_trim_value_ff;
reg [31:0] trim_ctrl_ff;
reg [RDY_W-1:0] ready_count_limit_ff;
reg [RDY_W-1:0] ready_count_shadow_ff;
reg [7:0] general_purpose_data_ff;
reg [REF_W-1:0] reference_count_ff;
reg [1:0] ref_sel_ff;
reg cal_start_ff;
reg [31:0] meas_ff;
reg [REF_W-1:0] ref_cnt_ff;
reg [RDY_W-1:0] rdy_cnt_ff;
reg [7:0] xtal_cnt_ff;
reg trim_applied_flag_ff;
reg settle_ready_flag_ff;
reg waking_ff;
reg [1:0] seq_ff;
reg [4:0] sync1_ff;
reg [4:0] sync2_ff;
reg [4:0] sync3_ff;
reg [7:0] nxt_trim;
reg [6:0] nxt_thermo;
reg [31:0] nxt_rdata;
reg sel_edge;
wire trim_apply_mode_sel;
wire [7:0] trim_apply_count;
wire [7:0] settle_threshold;
wire wr;
wire rd;
wire rdy_tick;
wire xtal_edge;
wire [3:0] osc_edges;
localparam SEQ_IDLE = 2'b00;
localparam SEQ_START = 2'b01;
localparam SEQ_SETTLE = 2'b10;
localparam SEQ_DONE = 2'b11;
assign trim_apply_mode_sel = trim_ctrl_ff[`XTC_MODE_BIT];
assign trim_apply_count = trim_ctrl_ff[`XTC_APPLY_CNT_LSB+7:`XTC_APPLY_CNT_LSB];
assign settle_threshold = trim_ctrl_ff[`XTC_SETTLE_LSB+7:`XTC_SETTLE_LSB];
assign wr = psel & penable & pwrite;
assign rd = psel & ~penable & ~pwrite;
////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, edges taken only past the second stage
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    sync1_ff <= 5'h00;
    sync2_ff <= 5'h00;
    sync3_ff <= 5'h00;
  end
  else
  begin
    sync1_ff <= {fast_crystal_tick, osc_ticks};
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
  end
end
assign osc_edges = sync2_ff[3:0] & ~sync3_ff[3:0];
assign xtal_edge = sync2_ff[4] & ~sync3_ff[4];
////////////////////////////////////////////////////////////////////////////////
// Trim decode
always @*
begin
  nxt_trim = trim_applied_flag_ff ? stored_trim_value_ff : crystal_trim_code_ff;
  case (nxt_trim[7:5])
    3'h0: nxt_thermo = 7'h00;
    3'h1: nxt_thermo = 7'h01;
    3'h2: nxt_thermo = 7'h03;
    3'h3: nxt_thermo = 7'h07;
    3'h4: nxt_thermo = 7'h0f;
    3'h5: nxt_thermo = 7'h1f;
    3'h6: nxt_thermo = 7'h3f;
    default: nxt_thermo = 7'h7f;
  endcase
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    trim_binary_caps_ff <= 5'h00;
    trim_thermo_caps_ff <= 7'h00;
  end
  else
  begin
    trim_binary_caps_ff <= nxt_trim[4:0];
    trim_thermo_caps_ff <= nxt_thermo;
  end
end
////////////////////////////////////////////////////////////////////////////////
// Ready sequencer; wake counts low-power ticks, power-up counts every cycle
assign rdy_tick = waking_ff ? lp_clk_tick : 1'b1;
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    seq_ff <= SEQ_IDLE;
    waking_ff <= 1'b0;
    rdy_cnt_ff <= {RDY_W{1'b0}};
    xtal_cnt_ff <= 8'h00;
    fast_crystal_en_ff <= 1'b0;
    trim_applied_flag_ff <= 1'b0;
    settle_ready_flag_ff <= 1'b0;
    crystal_ready_irq_ff <= 1'b0;
    core_on_fast_rc_ff <= 1'b1;
    ready_count_shadow_ff <= {RDY_W{1'b0}};
  end
  else
  begin
    case (seq_ff)
      SEQ_IDLE:
      begin
        if (power_up_start | wake_start)
        begin
          seq_ff <= SEQ_START;
          waking_ff <= wake_start & ~power_up_start;
          rdy_cnt_ff <= {RDY_W{1'b0}};
          xtal_cnt_ff <= 8'h00;
          fast_crystal_en_ff <= 1'b1;
          trim_applied_flag_ff <= 1'b0;
          settle_ready_flag_ff <= 1'b0;
          crystal_ready_irq_ff <= 1'b0;
          core_on_fast_rc_ff <= 1'b1;
        end
      end
      SEQ_START:
      begin
        if (rdy_tick)
          rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
        if (trim_apply_mode_sel ? xtal_current_drop :
            ({{(RDY_W-8){1'b0}}, trim_apply_count} - 1'b1 == rdy_cnt_ff))
        begin
          trim_applied_flag_ff <= 1'b1;
          seq_ff <= SEQ_SETTLE;
          if (trim_apply_mode_sel)
            ready_count_shadow_ff <= rdy_cnt_ff;
        end
      end
      SEQ_SETTLE:
      begin
        if (rdy_tick)
          rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
        if (xtal_edge && xtal_cnt_ff != 8'hff)
          xtal_cnt_ff <= xtal_cnt_ff + 1'b1;
        if (xtal_cnt_ff >= settle_threshold)
          settle_ready_flag_ff <= 1'b1;
        if (rdy_cnt_ff >= ready_count_limit_ff)
        begin
          crystal_ready_irq_ff <= 1'b1;
          core_on_fast_rc_ff <= 1'b0;
          seq_ff <= SEQ_DONE;
        end
      end
      SEQ_DONE:
      begin
        if (xtal_edge && xtal_cnt_ff != 8'hff)
          xtal_cnt_ff <= xtal_cnt_ff + 1'b1;
        if (xtal_cnt_ff >= settle_threshold)
          settle_ready_flag_ff <= 1'b1;
        if (wr && paddr == `XTC_STATUS_ADDR && pwdata[`XTC_ST_RDY_BIT])
          crystal_ready_irq_ff <= 1'b0;
        if (power_up_start | wake_start)
          seq_ff <= SEQ_IDLE;
      end
      default: seq_ff <= SEQ_IDLE;
    endcase
  end
end
////////////////////////////////////////////////////////////////////////////////
// Slow RC rate: 512 kHz while sequencer is in start or settle, else 32 kHz
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    slow_rc_fast_sel_ff <= 1'b0;
  else
    slow_rc_fast_sel_ff <= (seq_ff == SEQ_START) || (seq_ff == SEQ_SETTLE);
end
////////////////////////////////////////////////////////////////////////////////
// Reference counter measurement
always @*
begin
  case (ref_sel_ff)
    2'h0: sel_edge = osc_edges[0];
    2'h1: sel_edge = osc_edges[1];
    2'h2: sel_edge = osc_edges[2];
    default: sel_edge = osc_edges[3];
  endcase
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    cal_start_ff <= 1'b0;
    ref_cnt_ff <= {REF_W{1'b0}};
    meas_ff <= 32'h0000_0000;
  end
  else if (wr && paddr == `XTC_REF_SEL_ADDR && pwdata[`XTC_CAL_START_BIT] && !cal_start_ff)
  begin
    cal_start_ff <= 1'b1;
    ref_cnt_ff <= {REF_W{1'b0}};
    meas_ff <= 32'h0000_0000;
  end
  else if (cal_start_ff)
  begin
    if (ref_tick_16m)
      meas_ff <= meas_ff + 1'b1;
    if (sel_edge)
    begin
      ref_cnt_ff <= ref_cnt_ff + 1'b1;
      if (ref_cnt_ff + 1'b1 >= reference_count_ff)
        cal_start_ff <= 1'b0;
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// APB registers
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    crystal_trim_code_ff <= `XTC_TRIM_CODE_RST;
    stored_trim_value_ff <= `XTC_TRIM_CODE_RST;
    trim_ctrl_ff <= `XTC_TRIM_CTRL_RST;
    ready_count_limit_ff <= `XTC_RDY_LIMIT_RST;
    general_purpose_data_ff <= 8'h00;
    reference_count_ff <= `XTC_REF_COUNT_RST;
    ref_sel_ff <= 2'h0;
    slow_crystal_sleep_clk_ff <= 1'b0;
  end
  else if (wr)
  begin
    case (paddr)
      `XTC_TRIM_CODE_ADDR: crystal_trim_code_ff <= pwdata[7:0];
      `XTC_STORED_TRIM_ADDR: stored_trim_value_ff <= pwdata[7:0];
      `XTC_TRIM_CTRL_ADDR: trim_ctrl_ff <= {8'h00, pwdata[23:16], pwdata[15:8], 7'h00, pwdata[0]};
      `XTC_RDY_LIMIT_ADDR: ready_count_limit_ff <= pwdata[RDY_W-1:0];
      `XTC_GP_DATA_ADDR: general_purpose_data_ff <= pwdata[7:0];
      `XTC_REF_COUNT_ADDR: reference_count_ff <= pwdata[REF_W-1:0];
      `XTC_REF_SEL_ADDR: if (!cal_start_ff) ref_sel_ff <= pwdata[1:0];
      `XTC_SEQ_CTRL_ADDR: slow_crystal_sleep_clk_ff <= pwdata[`XTC_SEQ_SLEEP_BIT];
      default: ;
    endcase
  end
end
always @*
begin
  nxt_rdata = 32'h0000_0000;
  case (paddr)
    `XTC_TRIM_CODE_ADDR: nxt_rdata[7:0] = crystal_trim_code_ff;
    `XTC_STORED_TRIM_ADDR: nxt_rdata[7:0] = stored_trim_value_ff;
    `XTC_TRIM_CTRL_ADDR: nxt_rdata = trim_ctrl_ff;
    `XTC_RDY_LIMIT_ADDR: nxt_rdata[RDY_W-1:0] = ready_count_limit_ff;
    `XTC_RDY_SHADOW_ADDR: nxt_rdata[RDY_W-1:0] = ready_count_shadow_ff;
    `XTC_STATUS_ADDR: nxt_rdata[3:0] = {crystal_ready_irq_ff, fast_crystal_en_ff,
                                        trim_applied_flag_ff, settle_ready_flag_ff};
    `XTC_GP_DATA_ADDR: nxt_rdata[7:0] = general_purpose_data_ff;
    `XTC_REF_COUNT_ADDR: nxt_rdata[REF_W-1:0] = reference_count_ff;
    `XTC_REF_SEL_ADDR: nxt_rdata[2:0] = {cal_start_ff, ref_sel_ff};
    `XTC_RES_HIGH_ADDR: nxt_rdata[15:0] = meas_ff[31:16];
    `XTC_RES_LOW_ADDR: nxt_rdata[15:0] = meas_ff[15:0];
    `XTC_SEQ_CTRL_ADDR: nxt_rdata[1:0] = {slow_crystal_sleep_clk_ff, 1'b0};
    default: nxt_rdata = 32'h0000_0000;
  endcase
end
// No wait states: ready answers in the access phase's first cycle
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    prdata <= 32'h0000_0000;
    pready <= 1'b0;
    pslverr <= 1'b0;
  end
  else
  begin
    pready <= psel & ~penable;
    pslverr <= psel & ~penable & (paddr > `XTC_SEQ_CTRL_ADDR || paddr[1:0] != 2'b00);
    if (rd)
      prdata <= nxt_rdata;
  end
end
endmodule // xtc_trim_calib

//--- xtc_map.vh
`ifndef XTC_MAP_VH
`define XTC_MAP_VH
// Register byte offsets
`define XTC_TRIM_CODE_ADDR 12'h000
`define XTC_STORED_TRIM_ADDR 12'h004
`define XTC_TRIM_CTRL_ADDR 12'h008
`define XTC_RDY_LIMIT_ADDR 12'h00c
`define XTC_RDY_SHADOW_ADDR 12'h010
`define XTC_STATUS_ADDR 12'h014
`define XTC_GP_DATA_ADDR 12'h018
`define XTC_REF_COUNT_ADDR 12'h01c
`define XTC_REF_SEL_ADDR 12'h020
`define XTC_RES_HIGH_ADDR 12'h024
`define XTC_RES_LOW_ADDR 12'h028
`define XTC_SEQ_CTRL_ADDR 12'h02c
// Trim control fields
`define XTC_MODE_BIT 0
`define XTC_APPLY_CNT_LSB 8
`define XTC_SETTLE_LSB 16
// Reference select fields
`define XTC_CAL_START_BIT 2
// Status fields
`define XTC_ST_SETTLE_BIT 0
`define XTC_ST_TRIM_BIT 1
`define XTC_ST_FAST_XTAL_BIT 2
`define XTC_ST_RDY_BIT 3
// Sequencer control fields
`define XTC_SEQ_WAKE_BIT 0
`define XTC_SEQ_SLEEP_BIT 1
// Reset values
`define XTC_TRIM_CODE_RST 8'h00
`define XTC_TRIM_CTRL_RST 32'h0020_1000
`define XTC_RDY_LIMIT_RST 16'h0040
`define XTC_REF_COUNT_RST 16'h0100
`endif

//--- xtc_trim_calib_assertions.sv
`timescale 1ns/1ns
module xtc_trim_calib_assertions #(
  parameter RDY_W = 16,
  parameter REF_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire power_up_start,
  input wire wake_start,
  input wire lp_clk_tick,
  input wire xtal_current_drop,
  input wire fast_crystal_tick,
  input wire ref_tick_16m,
  input wire [3:0] osc_ticks,
  input wire fast_crystal_en_ff,
  input wire [4:0] trim_binary_caps_ff,
  input wire [6:0] trim_thermo_caps_ff,
  input wire crystal_ready_irq_ff,
  input wire core_on_fast_rc_ff,
  input wire slow_rc_fast_sel_ff,
  input wire slow_crystal_sleep_clk_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_irq_clr;
    psel && penable && pready && pwrite && paddr == 12'h014 && pwdata[3];
  endsequence
  ////////////////////////////////////////
  a_apb_answer: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_start_en: assert property ((power_up_start || wake_start) |-> ##[1:2] fast_crystal_en_ff)
    else $error("crystal not enabled");
  a_en_sticky: assert property (fast_crystal_en_ff |=> fast_crystal_en_ff)
    else $error("crystal enable dropped");
  a_seq_sel: assert property ($rose(fast_crystal_en_ff) |-> ##[0:1] slow_rc_fast_sel_ff)
    else $error("slow rc not fast");
  a_irq_core: assert property ($rose(crystal_ready_irq_ff) |-> ##[0:2] !core_on_fast_rc_ff)
    else $error("core stays on rc");
  a_core_cause: assert property ($fell(core_on_fast_rc_ff) |-> crystal_ready_irq_ff)
    else $error("core left rc early");
  a_thermo_code: assert property ((trim_thermo_caps_ff & (trim_thermo_caps_ff + 7'h01)) == 7'h00)
    else $error("bad thermometer code");
  a_irq_in_seq: assert property ($rose(crystal_ready_irq_ff) |-> $past(slow_rc_fast_sel_ff))
    else $error("irq outside sequence");
  a_irq_clear: assert property (s_irq_clr |-> ##[1:2] !crystal_ready_irq_ff)
    else $error("irq not cleared");
endmodule // xtc_trim_calib_assertions
bind xtc_trim_calib xtc_trim_calib_assertions #(.RDY_W(RDY_W), .REF_W(REF_W)) u_chk (.*);

//--- xtc_trim_calib_tb.sv
`timescale 1ns/1ns
module xtc_trim_calib_tb;
  logic pclk, presetn, psel, penable, pwrite, power_up_start, wake_start;
  logic xtal_current_drop, rerr;
  logic lp_clk_tick = 1'b0;
  logic fast_crystal_tick = 1'b0;
  logic ref_tick_16m = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [3:0] osc_ticks = 4'h0;
  logic [7:0] cyc = 8'h00;
  logic [7:0] codes [4] = '{8'h00, 8'hff, 8'ha7, 8'h3c};
  wire [31:0] prdata;
  wire pready, pslverr, fast_crystal_en_ff, crystal_ready_irq_ff, core_on_fast_rc_ff;
  wire slow_rc_fast_sel_ff, slow_crystal_sleep_clk_ff;
  wire [4:0] trim_binary_caps_ff;
  wire [6:0] trim_thermo_caps_ff;
  int err_count, tests_run, n;
  xtc_trim_calib xtc_trim_calib_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_up_start(power_up_start), .wake_start(wake_start), .lp_clk_tick(lp_clk_tick),
    .xtal_current_drop(xtal_current_drop), .fast_crystal_tick(fast_crystal_tick),
    .ref_tick_16m(ref_tick_16m), .osc_ticks(osc_ticks),
    .fast_crystal_en_ff(fast_crystal_en_ff), .trim_binary_caps_ff(trim_binary_caps_ff),
    .trim_thermo_caps_ff(trim_thermo_caps_ff), .crystal_ready_irq_ff(crystal_ready_irq_ff),
    .core_on_fast_rc_ff(core_on_fast_rc_ff), .slow_rc_fast_sel_ff(slow_rc_fast_sel_ff),
    .slow_crystal_sleep_clk_ff(slow_crystal_sleep_clk_ff)
  );
  initial
  begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // Free-running stand-ins for the oscillators
  always @(posedge pclk)
  begin
    cyc <= cyc + 8'h01;
    fast_crystal_tick <= cyc[0];
    ref_tick_16m <= cyc[2:0] == 3'h0;
    lp_clk_tick <= cyc[1:0] == 2'h0;
    osc_ticks <= cyc[7:4];
  end
  ////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    chk(32'(g >= lo && g <= hi), 32'h1);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input logic wake);
    @(posedge pclk);
    power_up_start <= !wake;
    wake_start <= wake;
    @(posedge pclk);
    power_up_start <= 0;
    wake_start <= 0;
  endtask
  task wt(input int lim);
    n = 0;
    while (crystal_ready_irq_ff !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    chk(crystal_ready_irq_ff, 32'h0);
    chk(core_on_fast_rc_ff, 32'h1);
    chk(fast_crystal_en_ff, 32'h0);
    apb(0, 12'h008, 32'h0);
    chk(rdata, 32'h0020_1000);
    apb(0, 12'h00c, 32'h0);
    chk(rdata, 32'h40);
    apb(0, 12'h01c, 32'h0);
    chk(rdata, 32'h100);
  endtask
  task t_trim;
    foreach (codes[i])
    begin
      apb(1, 12'h000, {24'h0, codes[i]});
      apb(0, 12'h000, 32'h0);
      chk(rdata, {24'h0, codes[i]});
      chk(trim_binary_caps_ff, codes[i][4:0]);
      chk(trim_thermo_caps_ff, (8'h01 << codes[i][7:5]) - 8'h01);
    end
  endtask
  task t_power;
    apb(1, 12'h004, 32'h5a);
    pulse(0);
    repeat (8) @(posedge pclk);
    chk(slow_rc_fast_sel_ff, 32'h1);
    chk(trim_binary_caps_ff, 32'h1c);
    repeat (16) @(posedge pclk);
    chk(trim_binary_caps_ff, 32'h1a);
    chk(trim_thermo_caps_ff, 32'h3);
    wt(100);
    rng(n + 25, 32'h3e, 32'h44);
    repeat (2) @(posedge pclk);
    chk(core_on_fast_rc_ff, 32'h0);
    apb(0, 12'h014, 32'h0);
    chk(rdata[3:0], 4'he);
    repeat (30) @(posedge pclk);
    apb(0, 12'h014, 32'h0);
    chk(rdata[3:0], 4'hf);
    apb(1, 12'h014, 32'h8);
    @(posedge pclk);
    chk(crystal_ready_irq_ff, 32'h0);
  endtask
  task t_wake;
    apb(1, 12'h004, 32'h21);
    apb(1, 12'h008, 32'h0020_1001);
    // First pulse only returns the finished sequence to idle
    pulse(1);
    pulse(1);
    repeat (40) @(posedge pclk);
    chk(32'(trim_binary_caps_ff !== 5'h01), 32'h1);
    xtal_current_drop <= 1;
    repeat (4) @(posedge pclk);
    apb(0, 12'h010, 32'h0);
    rng(rdata, 32'h8, 32'hc);
    chk(trim_binary_caps_ff, 32'h1);
    wt(400);
    rng(n + 49, 32'hf8, 32'h10c);
    xtal_current_drop <= 0;
    apb(1, 12'h014, 32'h8);
  endtask
  task t_calib;
    logic [31:0] m;
    apb(1, 12'h01c, 32'h4);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, 12'h020, 32'h4 | k);
      n = 0;
      do
      begin
        apb(0, 12'h020, 32'h0);
        n++;
      end
      while (rdata[2] !== 1'b0 && n < 500);
      chk(rdata[2], 32'h0);
      chk(rdata[1:0], k);
      apb(0, 12'h024, 32'h0);
      m[31:16] = rdata[15:0];
      apb(0, 12'h028, 32'h0);
      m[15:0] = rdata[15:0];
      rng(m, 32'hc << k, (32'h10 << k) + 32'h2);
    end
  endtask
  task t_misc;
    apb(0, 12'h030, 32'h0);
    chk({rerr, rdata[30:0]}, 32'h8000_0000);
    apb(1, 12'h018, 32'h20);
    apb(0, 12'h018, 32'h0);
    chk(rdata[7:0], 32'h20);
    apb(1, 12'h02c, 32'h2);
    repeat (2) @(posedge pclk);
    chk(slow_crystal_sleep_clk_ff, 32'h1);
    apb(1, 12'h01c, 32'hffff);
    apb(1, 12'h020, 32'h4);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h020, 32'h0);
    chk(rdata[2], 32'h0);
    chk(slow_crystal_sleep_clk_ff, 32'h0);
  endtask
  task test_done;
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    test_done;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, power_up_start, wake_start} = '0;
    xtal_current_drop = 1'b0;
    {paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_trim;
    t_power;
    t_wake;
    t_calib;
    t_misc;
    test_done;
  end
endmodule // xtc_trim_calib_tb
